// ---- i2c_line_filter.sv ----
// constants of the sensor serial port and the serial line glitch filter
`timescale 1ns/10ps
// ============================================================
// shared constants
package temp_i2c_pkg;
  localparam int        CLOCK_PERIOD_NS = 40;
  localparam int        LINK_PERIOD_PS  = 6000;
  localparam int        TIMEOUT_MS      = 30;
  localparam int        TIMEOUT_CYC     = TIMEOUT_MS * 1000000 / CLOCK_PERIOD_NS;
  localparam int        FILT_FS_NS      = 50;
  localparam int        FILT_HS_NS      = 10;
  localparam int        FILT_FS_CYC     = (FILT_FS_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int        FILT_HS_CYC     = (FILT_HS_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam logic [6:0] ADDR_LOW       = 7'h48;
  localparam logic [6:0] ADDR_HIGH      = 7'h49;
  localparam logic [4:0] HS_CMD_TOP     = 5'h01;
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [7:0] PTR_RESET      = 8'h00;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
endpackage : temp_i2c_pkg

// ============================================================
// two-flop synchroniser followed by a stability window
module i2c_line_filter
  import temp_i2c_pkg::*;
(
  input  wire logic link_clk,
  input  wire logic lrst_n,
  input  wire logic raw,
  input  wire logic hs_mode,
  output logic      filt_q
);
  logic       s1_q;
  logic       s2_q;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic       filt_d;
  logic [3:0] win;

  always_comb
  begin
    win    = hs_mode ? 4'(FILT_HS_CYC) : 4'(FILT_FS_CYC);
    cnt_d  = 4'h0;
    filt_d = filt_q;
    if (s2_q != filt_q)
    begin
      if (cnt_q >= win - 4'h1)
        filt_d = s2_q;
      else
        cnt_d = cnt_q + 4'h1;
    end
  end

  always_ff @(posedge link_clk)
  begin
    s1_q <= raw;
    s2_q <= s1_q;
    if (!lrst_n)
    begin
      cnt_q  <= 4'h0;
      filt_q <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_d;
      filt_q <= filt_d;
    end
  end
endmodule : i2c_line_filter

// ---- i2c_master_model.sv ----
// behavioural two-wire bus master driving the sensor serial port
`timescale 1ns/10ps
// ============================================================
// master model, timed in core clock cycles, changes on falling edges
module i2c_master_model
(
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // 20 cycles per phase, 80 per bit: about 312 kHz, well above the timeout rate
  localparam int PH = 20;
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wait_q(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_q
  // also serves as repeated start when scl is low
  task automatic start();
    sda_low = 1'b0;
    wait_q(PH);
    scl = 1'b1;
    wait_q(PH);
    sda_low = 1'b1;
    wait_q(PH);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    wait_q(PH);
    scl = 1'b1;
    wait_q(PH);
    sda_low = 1'b0;
    wait_q(PH);
  endtask : stop
  task automatic bit_x(input logic b, output logic s);
    sda_low = ~b;
    wait_q(PH);
    scl = 1'b1;
    wait_q(PH);
    s = sda;
    wait_q(PH);
    scl = 1'b0;
    wait_q(PH);
  endtask : bit_x
  // tx 8'hff leaves the line released for a read; ack_in 1 gives not-acknowledge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input logic ack_in, output logic ack_out);
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(tx[i], rx[i]);
    end
    bit_x(ack_in, ack_out);
  endtask : xfer
endmodule : i2c_master_model

// ---- tb_top.sv ----
// self-checking bench of the sensor serial port, timeout and alert flag
`timescale 1ns/10ps
module tb_top
  import temp_i2c_pkg::*;
;
  localparam int TO_CYC = 200;
  localparam int LIMIT  = 90000;
  logic               clock;
  logic               nrst;
  logic               link_clk;
  logic               scl;
  logic               sda_low;
  logic               sda;
  logic               sel;
  logic [15:0]        read_word;
  logic signed [15:0] temp_value;
  logic signed [15:0] upper_temp_limit;
  logic signed [15:0] lower_temp_limit;
  logic               alert_polarity;
  logic               interrupt_mode_select;
  logic               sda_out_q;
  logic               sda_oe_n_q;
  logic               wr_strobe_q;
  logic               alert_condition_flag_q;
  logic               alert_q;
  logic               hs_mode_q;
  logic [7:0]         pointer_q;
  logic [15:0]        wr_word_q;
  logic [7:0]         rx;
  logic               ack;
  logic [6:0]         a;
  logic [7:0]         p;
  logic [15:0]        w;
  logic               flag_m;
  int                 err_count;
  int                 checked;
  int                 strb_n;
  int                 cycles;
  int                 t;
  int                 u;
  int                 l;
  int unsigned        seed_v;
  // open drain wire with pull-up: any party pulling wins
  assign sda = ~sda_low & (sda_oe_n_q | sda_out_q);
  // ============================================================
  // clocks, design and partner
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial
  begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  temp_sensor_i2c_slave_alert #(.TIMEOUT_CYCLES(TO_CYC)) i_dut (
    .clock(clock), .nrst(nrst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
    .sda_out_q(sda_out_q), .sda_oe_n_q(sda_oe_n_q), .address_select_pin(sel),
    .read_word(read_word), .pointer_q(pointer_q), .wr_word_q(wr_word_q), .wr_strobe_q(wr_strobe_q),
    .temp_value(temp_value), .upper_temp_limit(upper_temp_limit), .lower_temp_limit(lower_temp_limit),
    .alert_polarity(alert_polarity), .interrupt_mode_select(interrupt_mode_select),
    .alert_condition_flag_q(alert_condition_flag_q), .alert_q(alert_q), .hs_mode_q(hs_mode_q));
  i2c_master_model i_master (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
  // ============================================================
  // checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("errors %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  // strobe lasts one core cycle, so it is counted at the falling edge
  always @(negedge clock)
  begin
    if (wr_strobe_q === 1'b1)
      strb_n++;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      err_count++;
      wrap_up();
    end
  end
  // ============================================================
  // bus transfers
  task automatic addr(input logic [6:0] ad, input logic rd, input logic exp_ack);
    i_master.start();
    i_master.xfer({ad, rd}, rx, 1'b1, ack);
    check(ack, !exp_ack, "address ack");
  endtask : addr
  // full word read ending in not-acknowledge; caller sends stop
  task automatic rd_word(input logic [6:0] ad, input logic [15:0] wd);
    read_word = wd;
    addr(ad, 1'b1, 1'b1);
    i_master.xfer(8'hff, rx, 1'b0, ack);
    check(rx, wd[15:8], "upper byte");
    i_master.xfer(8'hff, rx, 1'b1, ack);
    check(rx, wd[7:0], "lower byte");
    check(ack, 1'b1, "released at nack");
  endtask : rd_word
  // ============================================================
  // main sequence
  initial
  begin
    nrst = 1'b0; sel = 1'b0; read_word = '0; temp_value = '0;
    upper_temp_limit = 16'sd5; lower_temp_limit = -16'sd5;
    alert_polarity = 1'b0; interrupt_mode_select = 1'b0;
    err_count = 0; checked = 0; cycles = 0; strb_n = 0;
    seed_v = $urandom(71102);
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    repeat (5) @(negedge clock);
    check(sda_oe_n_q, 1'b1, "idle release");
    check(hs_mode_q, 1'b0, "hs at reset");
    check(pointer_q, 8'h00, "pointer at reset");
    check(wr_word_q, 16'h0000, "word at reset");
    check(sda_out_q, 1'b0, "open drain low value");
    check(alert_q, 1'b0, "alert at reset");
    for (int s = 0; s < 2; s++)
    begin
      sel = s[0];
      repeat (8) @(negedge clock);
      a = sel ? 7'h49 : 7'h48;
      addr(a ^ 7'h01, 1'b0, 1'b0);
      i_master.stop();
      p = 8'($urandom());
      w = 16'($urandom());
      addr(a, 1'b0, 1'b1);
      i_master.xfer(p, rx, 1'b1, ack);
      check(ack, 1'b0, "pointer ack");
      repeat (8) @(negedge clock);
      check(pointer_q, p, "pointer");
      i_master.xfer(w[15:8], rx, 1'b1, ack);
      check(ack, 1'b0, "upper ack");
      i_master.xfer(w[7:0], rx, 1'b1, ack);
      check(ack, 1'b0, "lower ack");
      repeat (8) @(negedge clock);
      check(wr_word_q, w, "written word");
      i_master.xfer(8'($urandom()), rx, 1'b1, ack);
      check(ack, 1'b0, "extra byte ack");
      i_master.stop();
      check(16'(strb_n), 16'(s + 1), "one strobe per word");
      for (int r = 0; r < 2; r++)
      begin
        rd_word(a, 16'($urandom()));
        i_master.stop();
        check(sda_oe_n_q, 1'b1, "released after stop");
        check(pointer_q, p, "pointer kept");
      end
      w = 16'($urandom()) | 16'h0080;
      read_word = w;
      addr(a, 1'b1, 1'b1);
      i_master.xfer(8'hff, rx, 1'b0, ack);
      check(rx, w[15:8], "upper only");
      i_master.stop();
      check(sda_oe_n_q, 1'b1, "released after upper");
    end
    i_master.start();
    i_master.xfer({5'h01, 3'($urandom())}, rx, 1'b1, ack);
    check(ack, 1'b1, "hs command not acked");
    check(hs_mode_q, 1'b1, "hs entered");
    rd_word(a, 16'($urandom()));
    check(hs_mode_q, 1'b1, "hs kept");
    i_master.stop();
    repeat (8) @(negedge clock);
    check(hs_mode_q, 1'b0, "hs left on stop");
    // device holds sda low with bit 15 of zero while the master stalls scl
    read_word = 16'($urandom()) & 16'h7fff;
    addr(a, 1'b1, 1'b1);
    i_master.wait_q(10);
    check(sda, 1'b0, "device drives zero");
    i_master.wait_q(TO_CYC + 40);
    check(sda_oe_n_q, 1'b1, "timeout release");
    i_master.xfer({a, 1'b0}, rx, 1'b1, ack);
    check(ack, 1'b1, "ignored after timeout");
    i_master.stop();
    rd_word(a, 16'($urandom()));
    i_master.stop();
    // a read acked past the lower byte starts the word again
    w = 16'($urandom());
    read_word = w;
    addr(a, 1'b1, 1'b1);
    i_master.xfer(8'hff, rx, 1'b0, ack);
    check(rx, w[15:8], "long read upper");
    i_master.xfer(8'hff, rx, 1'b0, ack);
    check(rx, w[7:0], "long read lower");
    i_master.xfer(8'hff, rx, 1'b1, ack);
    check(rx, w[15:8], "long read repeat");
    check(ack, 1'b1, "long read released");
    i_master.stop();
    // alert flag against a running model of the limits
    flag_m = 1'b0;
    for (int k = 0; k < 80; k++)
    begin
      t = int'($urandom_range(0, 16)) - 8;
      u = int'($urandom_range(0, 6));
      l = -int'($urandom_range(0, 6));
      temp_value = t[15:0];
      upper_temp_limit = u[15:0];
      lower_temp_limit = l[15:0];
      alert_polarity = 1'($urandom());
      interrupt_mode_select = 1'($urandom());
      if (t >= u)
        flag_m = alert_polarity;
      else if (t <= l)
        flag_m = ~alert_polarity;
      @(negedge clock);
      check(alert_condition_flag_q, flag_m, "alert flag");
      check(alert_q, interrupt_mode_select & flag_m, "alert pin");
    end
    wrap_up();
  end
endmodule : tb_top

// ---- temp_sensor_i2c_slave_alert.sv ----
// serial slave port, bus timeout and alert flag of the temperature sensor
// What this block does
// - on read address, ack then send upper byte of pointed register
// - after master ack of upper byte, send lower byte
// - master nack, start or stop ends read; device releases data line
// - alert pin carries the flag only when interrupt mode is one
// - polarity zero: flag 0 at/above upper limit, 1 at/below lower limit
// - polarity one: flag inverted against polarity zero
// - without high-speed entry, filtering suits fast-mode rates
// - first byte 00001xxx enters high speed, not acknowledged
// - high speed kept across repeated start, left on stop
// - clock low about 30 ms resets the port and releases data
// - after timeout, ignore the bus until a new start
// - idle bus: device pulls neither line low
// - start is data falling while clock high
// - stop is data rising while clock high; either ends transfer
// - any number of bytes between start and stop
// - own address is acknowledged by pulling data low
// - address 0x48 or 0x49 chosen by the address select pin
// - pointer keeps last written value
// - first written byte loads pointer, later bytes write the register
// - msb first, words upper byte first
`timescale 1ns/10ps
module temp_sensor_i2c_slave_alert
  import temp_i2c_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire logic               link_clk,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out_q,
  output logic                    sda_oe_n_q,
  input  wire logic               address_select_pin,
  input  wire logic [15:0]        read_word,
  output logic [7:0]              pointer_q,
  output logic [15:0]             wr_word_q,
  output logic                    wr_strobe_q,
  input  wire logic signed [15:0] temp_value,
  input  wire logic signed [15:0] upper_temp_limit,
  input  wire logic signed [15:0] lower_temp_limit,
  input  wire logic               alert_polarity,
  input  wire logic               interrupt_mode_select,
  output logic                    alert_condition_flag_q,
  output logic                    alert_q,
  output logic                    hs_mode_q
);
  typedef enum logic [2:0] {IDLE, ADDR, ADDR_ACK, RX, RX_ACK, TX, TX_ACK} link_state_e;

  // ============================================================
  // core domain: timeout, read word offer, write capture, alert
  logic        scl_c1_q, scl_c2_q;
  logic [19:0] tmo_cnt_q, tmo_cnt_d;
  logic        tmo_tgl_q, tmo_tgl_d;
  logic        rd_req_q, rd_req_d;
  logic [15:0] rd_hold_q, rd_hold_d;
  logic        ack_c1_q, ack_c2_q;
  logic [2:0]  ptr_s_q, wr_s_q;
  logic [7:0]  pointer_d;
  logic [15:0] wr_word_d;
  logic        wr_strobe_d, ac_d, alert_d;
  // link side holds, read by core only after their toggle has crossed
  logic [7:0]  ptr_hold_q, ptr_hold_d;
  logic [15:0] wr_hold_q, wr_hold_d;
  logic        ptr_tgl_q, ptr_tgl_d, wr_tgl_q, wr_tgl_d;
  logic        rd_l3_q;

  always_comb
  begin
    tmo_cnt_d = 20'h0;
    tmo_tgl_d = tmo_tgl_q;
    if (!scl_c2_q)
    begin
      if (tmo_cnt_q == 20'(TIMEOUT_CYCLES - 1))
        tmo_cnt_d = tmo_cnt_q;
      else
        tmo_cnt_d = tmo_cnt_q + 20'h1;
      if (tmo_cnt_q == 20'(TIMEOUT_CYCLES - 2))
        tmo_tgl_d = ~tmo_tgl_q;
    end
    // free-running handshake keeps a fresh word ready for the link
    rd_req_d  = rd_req_q;
    rd_hold_d = rd_hold_q;
    if (ack_c2_q == rd_req_q)
    begin
      rd_hold_d = read_word;
      rd_req_d  = ~rd_req_q;
    end
    pointer_d   = (ptr_s_q[2] != ptr_s_q[1]) ? ptr_hold_q : pointer_q;
    wr_strobe_d = wr_s_q[2] != wr_s_q[1];
    wr_word_d   = wr_strobe_d ? wr_hold_q : wr_word_q;
    ac_d = alert_condition_flag_q;
    if (temp_value >= upper_temp_limit)
      ac_d = alert_polarity;
    else if (temp_value <= lower_temp_limit)
      ac_d = ~alert_polarity;
    alert_d = interrupt_mode_select & ac_d;
  end

  always_ff @(posedge clock)
  begin
    scl_c1_q <= scl_in;
    scl_c2_q <= scl_c1_q;
    ack_c1_q <= rd_l3_q;
    ack_c2_q <= ack_c1_q;
    if (!nrst)
    begin
      tmo_cnt_q              <= 20'h0;
      tmo_tgl_q              <= 1'b0;
      rd_req_q               <= 1'b0;
      rd_hold_q              <= WORD_RESET;
      ptr_s_q                <= 3'h0;
      wr_s_q                 <= 3'h0;
      pointer_q              <= PTR_RESET;
      wr_word_q              <= WORD_RESET;
      wr_strobe_q            <= 1'b0;
      alert_condition_flag_q <= 1'b0;
      alert_q                <= 1'b0;
    end
    else
    begin
      tmo_cnt_q              <= tmo_cnt_d;
      tmo_tgl_q              <= tmo_tgl_d;
      rd_req_q               <= rd_req_d;
      rd_hold_q              <= rd_hold_d;
      ptr_s_q                <= {ptr_s_q[1:0], ptr_tgl_q};
      wr_s_q                 <= {wr_s_q[1:0], wr_tgl_q};
      pointer_q              <= pointer_d;
      wr_word_q              <= wr_word_d;
      wr_strobe_q            <= wr_strobe_d;
      alert_condition_flag_q <= ac_d;
      alert_q                <= alert_d;
    end
  end

  alert_pol0_a: assert property (@(posedge clock) disable iff (!nrst)
    (!alert_polarity && temp_value >= upper_temp_limit) |=> !alert_condition_flag_q)
    else $error("flag not cleared at upper limit with polarity zero");
  alert_pol1_a: assert property (@(posedge clock) disable iff (!nrst)
    (alert_polarity && temp_value < upper_temp_limit && temp_value <= lower_temp_limit)
    |=> !alert_condition_flag_q)
    else $error("flag not cleared at lower limit with polarity one");
  alert_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    !interrupt_mode_select |=> !alert_q)
    else $error("alert pin active outside interrupt mode");

  // ============================================================
  // link domain: reset sync, crossings, filters
  logic       lr1_q, lrst_n_q;
  logic [2:0] tmo_s_q;
  logic       rd_l1_q, rd_l2_q;
  logic [15:0] rd_word_q;
  logic       adsel1_q, adsel2_q;
  logic       scl_f, sda_f, scl_p_q, sda_p_q;

  always_ff @(posedge link_clk)
  begin
    lr1_q    <= nrst;
    lrst_n_q <= lr1_q;
    adsel1_q <= address_select_pin;
    adsel2_q <= adsel1_q;
    tmo_s_q  <= {tmo_s_q[1:0], tmo_tgl_q};
    rd_l1_q  <= rd_req_q;
    rd_l2_q  <= rd_l1_q;
    rd_l3_q  <= rd_l2_q;
    scl_p_q  <= scl_f;
    sda_p_q  <= sda_f;
    if (rd_l2_q != rd_l3_q)
      rd_word_q <= rd_hold_q;
  end

  // long window by default keeps the port at fast-mode rates
  i2c_line_filter u_scl_filt (
    .link_clk (link_clk),
    .lrst_n   (lrst_n_q),
    .raw      (scl_in),
    .hs_mode  (hs_mode_q),
    .filt_q   (scl_f)
  );
  i2c_line_filter u_sda_filt (
    .link_clk (link_clk),
    .lrst_n   (lrst_n_q),
    .raw      (sda_in),
    .hs_mode  (hs_mode_q),
    .filt_q   (sda_f)
  );

  // ============================================================
  // link domain: protocol engine
  link_state_e state_q, state_d;
  logic [3:0]  bit_q, bit_d;
  logic [7:0]  sh_q, sh_d;
  logic [7:0]  lo_q, lo_d;
  logic [7:0]  hi_w_q, hi_w_d;
  logic        rw_q, rw_d, first_q, first_d, half_q, half_d, nack_q, nack_d;
  logic        oe_n_d, hs_d;
  logic        scl_rise, scl_fall, start_c, stop_c, tmo_evt, byte_done;
  logic [6:0]  own_addr;

  always_comb
  begin
    scl_rise  = scl_f & ~scl_p_q;
    scl_fall  = ~scl_f & scl_p_q;
    start_c   = scl_f & scl_p_q & sda_p_q & ~sda_f;
    stop_c    = scl_f & scl_p_q & ~sda_p_q & sda_f;
    tmo_evt   = tmo_s_q[2] != tmo_s_q[1];
    byte_done = scl_fall && bit_q == BYTE_BITS;
    own_addr  = adsel2_q ? ADDR_HIGH : ADDR_LOW;
    state_d   = state_q;
    bit_d     = bit_q;
    sh_d      = sh_q;
    lo_d      = lo_q;
    hi_w_d    = hi_w_q;
    rw_d      = rw_q;
    first_d   = first_q;
    half_d    = half_q;
    nack_d    = nack_q;
    oe_n_d    = sda_oe_n_q;
    hs_d      = hs_mode_q;
    ptr_hold_d = ptr_hold_q;
    ptr_tgl_d  = ptr_tgl_q;
    wr_hold_d  = wr_hold_q;
    wr_tgl_d   = wr_tgl_q;
    if (tmo_evt)
    begin
      state_d = IDLE;
      oe_n_d  = 1'b1;
      hs_d    = 1'b0;
    end
    else if (stop_c)
    begin
      state_d = IDLE;
      oe_n_d  = 1'b1;
      hs_d    = 1'b0;
    end
    else if (start_c)
    begin
      state_d = ADDR;
      bit_d   = 4'h0;
      oe_n_d  = 1'b1;
    end
    else
    begin
      case (state_q)
        IDLE: oe_n_d = 1'b1;
        ADDR, RX:
        begin
          if (scl_rise && bit_q != BYTE_BITS)
          begin
            sh_d  = {sh_q[6:0], sda_f};
            bit_d = bit_q + 4'h1;
          end
          else if (byte_done && state_q == ADDR)
          begin
            if (sh_q[7:3] == HS_CMD_TOP)
            begin
              hs_d    = 1'b1;
              state_d = IDLE;
            end
            else if (sh_q[7:1] == own_addr)
            begin
              oe_n_d  = 1'b0;
              rw_d    = sh_q[0];
              state_d = ADDR_ACK;
            end
            else
              state_d = IDLE;
          end
          else if (byte_done)
          begin
            oe_n_d  = 1'b0;
            state_d = RX_ACK;
            first_d = 1'b0;
            if (first_q)
            begin
              ptr_hold_d = sh_q;
              ptr_tgl_d  = ~ptr_tgl_q;
              half_d     = 1'b0;
            end
            else if (!half_q)
            begin
              hi_w_d = sh_q;
              half_d = 1'b1;
            end
            else
            begin
              wr_hold_d = {hi_w_q, sh_q};
              wr_tgl_d  = ~wr_tgl_q;
              half_d    = 1'b0;
            end
          end
        end
        ADDR_ACK:
        begin
          if (scl_fall)
          begin
            bit_d = 4'h0;
            if (rw_q)
            begin
              sh_d    = rd_word_q[15:8];
              lo_d    = rd_word_q[7:0];
              oe_n_d  = rd_word_q[15];
              half_d  = 1'b0;
              state_d = TX;
            end
            else
            begin
              oe_n_d  = 1'b1;
              first_d = 1'b1;
              half_d  = 1'b0;
              state_d = RX;
            end
          end
        end
        RX_ACK:
        begin
          if (scl_fall)
          begin
            oe_n_d  = 1'b1;
            bit_d   = 4'h0;
            state_d = RX;
          end
        end
        TX:
        begin
          if (scl_fall)
          begin
            if (bit_q == BYTE_BITS - 4'h1)
            begin
              oe_n_d  = 1'b1;
              state_d = TX_ACK;
            end
            else
            begin
              sh_d   = {sh_q[6:0], 1'b0};
              oe_n_d = sh_q[6];
              bit_d  = bit_q + 4'h1;
            end
          end
        end
        TX_ACK:
        begin
          if (scl_rise)
            nack_d = sda_f;
          if (scl_fall)
          begin
            bit_d = 4'h0;
            if (nack_q)
            begin
              oe_n_d  = 1'b1;
              state_d = IDLE;
            end
            else
            begin
              // a long read restarts with the upper byte of the word then held in rd_word_q
              sh_d    = half_q ? rd_word_q[15:8] : lo_q;
              oe_n_d  = half_q ? rd_word_q[15] : lo_q[7];
              lo_d    = half_q ? rd_word_q[7:0] : lo_q;
              half_d  = ~half_q;
              state_d = TX;
            end
          end
        end
        default: state_d = IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (!lrst_n_q)
    begin
      state_q    <= IDLE;
      bit_q      <= 4'h0;
      sh_q       <= 8'h00;
      lo_q       <= 8'h00;
      hi_w_q     <= 8'h00;
      rw_q       <= 1'b0;
      first_q    <= 1'b0;
      half_q     <= 1'b0;
      nack_q     <= 1'b1;
      sda_oe_n_q <= 1'b1;
      sda_out_q  <= 1'b0;
      hs_mode_q  <= 1'b0;
      ptr_hold_q <= PTR_RESET;
      ptr_tgl_q  <= 1'b0;
      wr_hold_q  <= WORD_RESET;
      wr_tgl_q   <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      bit_q      <= bit_d;
      sh_q       <= sh_d;
      lo_q       <= lo_d;
      hi_w_q     <= hi_w_d;
      rw_q       <= rw_d;
      first_q    <= first_d;
      half_q     <= half_d;
      nack_q     <= nack_d;
      sda_oe_n_q <= oe_n_d;
      sda_out_q  <= 1'b0;
      hs_mode_q  <= hs_d;
      ptr_hold_q <= ptr_hold_d;
      ptr_tgl_q  <= ptr_tgl_d;
      wr_hold_q  <= wr_hold_d;
      wr_tgl_q   <= wr_tgl_d;
    end
  end

  start_to_addr_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
    (start_c && !tmo_evt && !stop_c) |=> state_q == ADDR && sda_oe_n_q)
    else $error("start did not open an address phase");
  stop_release_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
    stop_c |=> state_q == IDLE && sda_oe_n_q && !hs_mode_q)
    else $error("stop did not end transfer and high speed");
  hs_enter_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
    (state_q == ADDR && byte_done && sh_q[7:3] == HS_CMD_TOP && !tmo_evt && !stop_c && !start_c)
    |=> hs_mode_q && sda_oe_n_q)
    else $error("high speed command mishandled");
  hs_hold_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
    (hs_mode_q && start_c && !stop_c && !tmo_evt) |=> hs_mode_q)
    else $error("high speed lost on repeated start");
  addr_ack_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
    (state_q == ADDR && byte_done && sh_q[7:1] == own_addr && !tmo_evt && !stop_c && !start_c)
    |=> !sda_oe_n_q [*2])
    else $error("own address not acknowledged");
  timeout_idle_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
    tmo_evt |=> state_q == IDLE && sda_oe_n_q && !hs_mode_q)
    else $error("timeout did not reset the port");
  idle_quiet_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
    (state_q == IDLE && $past(state_q) == IDLE) |-> sda_oe_n_q)
    else $error("data line pulled while idle");
  nack_end_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
    (state_q == TX_ACK && nack_q && scl_fall && !tmo_evt && !stop_c && !start_c)
    |=> state_q == IDLE && sda_oe_n_q)
    else $error("read continued after not-acknowledge");
endmodule : temp_sensor_i2c_slave_alert
